// ### rtl/i2c_master_addr_count_clkdiv.v
// Overview of operation
// - Byte total is captured from read length setting when a read sequence starts.
// - Bit 8 of read length setting extends the count beyond 256 bytes.
// - Low eight bits hold byte total minus one; zero reads one byte.
// - Read-only progress register shows the low eight bits of bytes received in current read.
// - In 7-bit mode bits 7:1 of first address give the target address.
// - Bit 0 of first address selects read (1) or write (0).
// - In 10-bit mode bits 2:1 carry address bits nine and eight.
// - Low address byte is sent after the prefix, only in 10-bit mode.
// - Divider upper byte sets the SCL high time.
// - Divider lower byte sets the SCL low time.
// - Bit 10 of target side control enables the target transmit interrupt.
`include "i2c_rd_map.vh"
module i2c_master_addr_count_clkdiv (
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire [31:0] s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output wire        s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output wire        s_axi_wready_out,
	output wire [1:0]  s_axi_bresp_out,
	output wire        s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	input  wire [31:0] s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output wire        s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0]  s_axi_rresp_out,
	output wire        s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe_out,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_out,
	input  wire        target_tx_done_in,
	output wire        target_tx_irq_out
);
	// ==========================================
	// States
	localparam ST_IDLE      = 4'h0;
	localparam ST_START_A   = 4'h1;
	localparam ST_START_B   = 4'h2;
	localparam ST_BIT_LOW   = 4'h3;
	localparam ST_BIT_HIGH  = 4'h4;
	localparam ST_WAIT_FIFO = 4'h5;
	localparam ST_RS_LOW    = 4'h6;
	localparam ST_STOP_LOW  = 4'h7;
	localparam ST_STOP_HIGH = 4'h8;
	localparam ST_STOP_END  = 4'h9;
	localparam PH_ADR1      = 2'h0;
	localparam PH_ADR2      = 2'h1;
	localparam PH_DATA      = 2'h2;

	// ==========================================
	// Registers
	reg [15:0] read_length_setting_r;
	reg [7:0]  target_addr_first_r;
	reg [7:0]  target_addr_low_byte_r;
	reg [15:0] scl_period_divider_r;
	reg [10:0] target_side_control_r;
	reg        ten_bit_mode_r;
	reg        nack_flag_r;
	reg        done_flag_r;
	reg [31:0] awaddr_r;
	reg        aw_full_r;
	reg [31:0] wdata_r;
	reg [3:0]  wstrb_r;
	reg        w_full_r;
	reg        bvalid_r;
	reg [1:0]  bresp_r;
	reg        rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0]  rresp_r;
	reg        scl_m_r;
	reg        scl_s_r;
	reg        sda_m_r;
	reg        sda_s_r;
	reg [3:0]  state_r;
	reg        reload_r;
	reg [3:0]  bit_idx_r;
	reg [7:0]  shift_r;
	reg [1:0]  phase_r;
	reg        rd_r;
	reg        ten_r;
	reg        adr2_sent_r;
	reg [8:0]  total_r;
	reg [8:0]  rx_cnt_r;
	reg        push_r;
	reg [7:0]  push_data_r;
	reg        scl_low_r;
	reg        sda_low_r;
	reg        sda_pre_r;
	reg        irq_r;

	wire        wr_go;
	wire        ar_go;
	wire        go;
	wire        busy;
	wire        last;
	wire        high_wait;
	wire        expired;
	wire        fifo_ready;
	wire        fifo_valid;
	wire [7:0]  fifo_data;
	wire [5:0]  fifo_level;
	wire        pop;
	wire        want_sda_low;
	wire [31:0] wmask;
	wire [31:0] wval;
	wire [31:0] rd_val;
	wire        rd_hit;
	wire [31:0] len_merged;
	wire [31:0] div_merged;
	wire [31:0] tctl_merged;

	// ==========================================
	// AXI4-Lite write channel
	assign s_axi_awready_out = ~aw_full_r;
	assign s_axi_wready_out  = ~w_full_r;
	assign s_axi_bvalid_out  = bvalid_r;
	assign s_axi_bresp_out   = bresp_r;
	assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign go    = wr_go & (awaddr_r == `OFS_CTRL) & wmask[`CTRL_START_BIT]
		& wdata_r[`CTRL_START_BIT] & ~busy;

	function [31:0] merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [31:0] mask;
		begin
			merge = (old_val & ~mask) | (new_val & mask);
		end
	endfunction

	assign wval = wdata_r;
	assign len_merged  = merge({16'h0000, read_length_setting_r},
		{23'h000000, wval[8:0]}, wmask);
	assign div_merged  = merge({16'h0000, scl_period_divider_r}, wval, wmask);
	assign tctl_merged = merge({21'h000000, target_side_control_r},
		{21'h000000, wval[10:0]}, wmask);

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			aw_full_r              <= 1'b0;
			w_full_r               <= 1'b0;
			awaddr_r               <= 32'h00000000;
			wdata_r                <= 32'h00000000;
			wstrb_r                <= 4'h0;
			bvalid_r               <= 1'b0;
			bresp_r                <= `RESP_OKAY;
			read_length_setting_r  <= `RST_READ_LENGTH;
			target_addr_first_r    <= `RST_ADDR_FIRST;
			target_addr_low_byte_r <= `RST_ADDR_LOW;
			scl_period_divider_r   <= `RST_SCL_DIVIDER;
			target_side_control_r  <= `RST_TARGET_CTRL;
			ten_bit_mode_r         <= 1'b0;
		end else begin
			if (s_axi_awvalid_in & ~aw_full_r) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in & ~w_full_r) begin
				w_full_r <= 1'b1;
				wdata_r  <= s_axi_wdata_in;
				wstrb_r  <= s_axi_wstrb_in;
			end
			if (bvalid_r & s_axi_bready_in) begin
				bvalid_r <= 1'b0;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= `RESP_OKAY;
				case (awaddr_r)
				`OFS_CTRL: begin
					if (wstrb_r[0]) begin
						ten_bit_mode_r <= wval[`CTRL_TEN_BIT];
					end
				end
				`OFS_STATUS, `OFS_RX_DATA, `OFS_RX_PROGRESS: begin
				end
				`OFS_READ_LENGTH: begin
					read_length_setting_r <= len_merged[15:0];
				end
				`OFS_ADDR_FIRST: begin
					if (wstrb_r[0]) begin
						target_addr_first_r <= wval[7:0];
					end
				end
				`OFS_ADDR_LOW: begin
					if (wstrb_r[0]) begin
						target_addr_low_byte_r <= wval[7:0];
					end
				end
				`OFS_SCL_DIVIDER: begin
					scl_period_divider_r <= div_merged[15:0];
				end
				`OFS_TARGET_CTRL: begin
					target_side_control_r <= tctl_merged[10:0];
				end
				default: begin
					bresp_r <= `RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ==========================================
	// AXI4-Lite read channel
	assign s_axi_arready_out = ~rvalid_r;
	assign s_axi_rvalid_out  = rvalid_r;
	assign s_axi_rdata_out   = rdata_r;
	assign s_axi_rresp_out   = rresp_r;
	assign ar_go  = s_axi_arvalid_in & ~rvalid_r;
	assign pop    = ar_go & (s_axi_araddr_in == `OFS_RX_DATA);
	assign rd_hit = (s_axi_araddr_in[31:8] == `OFS_CTRL >> 8)
		& ((s_axi_araddr_in[7:0] <= 8'h28) & (s_axi_araddr_in[1:0] == 2'h0))
		& (s_axi_araddr_in[7:0] != 8'h0c) & (s_axi_araddr_in[7:0] != 8'h20);

	assign rd_val =
		(s_axi_araddr_in == `OFS_CTRL)        ? {30'h0, ten_bit_mode_r, 1'b0} :
		(s_axi_araddr_in == `OFS_STATUS)      ? {23'h0, fifo_level, done_flag_r,
			nack_flag_r, busy} :
		(s_axi_araddr_in == `OFS_RX_DATA)     ? {24'h0, fifo_valid ? fifo_data : 8'h00} :
		(s_axi_araddr_in == `OFS_READ_LENGTH) ? {16'h0, read_length_setting_r} :
		(s_axi_araddr_in == `OFS_RX_PROGRESS) ? {24'h0, rx_cnt_r[7:0]} :
		(s_axi_araddr_in == `OFS_ADDR_FIRST)  ? {24'h0, target_addr_first_r} :
		(s_axi_araddr_in == `OFS_ADDR_LOW)    ? {24'h0, target_addr_low_byte_r} :
		(s_axi_araddr_in == `OFS_SCL_DIVIDER) ? {16'h0, scl_period_divider_r} :
		(s_axi_araddr_in == `OFS_TARGET_CTRL) ? {21'h0, target_side_control_r} :
		32'h00000000;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= `RESP_OKAY;
		end else if (ar_go) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_val;
			rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			rvalid_r <= 1'b0;
		end
	end

	// ==========================================
	// Pin synchronisers and target interrupt gate
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			irq_r   <= 1'b0;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			irq_r   <= target_tx_done_in & target_side_control_r[`TX_IRQ_EN_BIT];
		end
	end

	assign target_tx_irq_out = irq_r;

	// ==========================================
	// Bit timing and receive buffer
	assign busy      = (state_r != ST_IDLE);
	assign last      = (rx_cnt_r == total_r);
	assign high_wait = (state_r == ST_BIT_HIGH) | (state_r == ST_START_A)
		| (state_r == ST_STOP_HIGH);

	scl_span_timer u_timer (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.load_in     (reload_r | (high_wait & ~scl_s_r)),
		.span_in     ((high_wait | (state_r == ST_START_B) | (state_r == ST_STOP_END))
			? scl_period_divider_r[15:8] : scl_period_divider_r[7:0]),
		.expired_out (expired)
	);

	rx_byte_fifo #(
		.WIDTH (8),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (push_r),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_data_r),
		.out_valid_out (fifo_valid),
		.out_ready_in  (pop),
		.out_data_out  (fifo_data),
		.level_out     (fifo_level)
	);

	// ==========================================
	// Pin drive
	assign want_sda_low =
		(state_r == ST_START_B) | (state_r == ST_STOP_LOW) | (state_r == ST_STOP_HIGH) |
		(((state_r == ST_BIT_LOW) | (state_r == ST_BIT_HIGH)) &
		((phase_r != PH_DATA) ? (~bit_idx_r[3] & ~shift_r[7])
		: (bit_idx_r[3] & ~last)));
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = scl_low_r;
	assign sda_oe_out = sda_low_r;

	// ==========================================
	// Transfer sequencer
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r     <= ST_IDLE;
			reload_r    <= 1'b0;
			bit_idx_r   <= 4'h0;
			shift_r     <= 8'h00;
			phase_r     <= PH_ADR1;
			rd_r        <= 1'b0;
			ten_r       <= 1'b0;
			adr2_sent_r <= 1'b0;
			total_r     <= 9'h000;
			rx_cnt_r    <= 9'h000;
			push_r      <= 1'b0;
			push_data_r <= 8'h00;
			scl_low_r   <= 1'b0;
			sda_low_r   <= 1'b0;
			sda_pre_r   <= 1'b0;
			nack_flag_r <= 1'b0;
			done_flag_r <= 1'b0;
		end else begin
			reload_r  <= 1'b0;
			push_r    <= 1'b0;
			scl_low_r <= (state_r == ST_BIT_LOW) | (state_r == ST_WAIT_FIFO)
				| (state_r == ST_RS_LOW) | (state_r == ST_STOP_LOW);
			// SDA moves one cycle after SCL so data bits never change while SCL is high
			sda_pre_r <= want_sda_low;
			sda_low_r <= sda_pre_r;
			if (wr_go & (awaddr_r == `OFS_STATUS) & wstrb_r[0]
				& wdata_r[`STAT_DONE_BIT]) begin
				done_flag_r <= 1'b0;
			end
			case (state_r)
			ST_IDLE: begin
				if (go) begin
					total_r     <= read_length_setting_r[8:0];
					rx_cnt_r    <= 9'h000;
					rd_r        <= target_addr_first_r[`DIR_READ_BIT];
					ten_r       <= ten_bit_mode_r;
					adr2_sent_r <= 1'b0;
					nack_flag_r <= 1'b0;
					phase_r     <= PH_ADR1;
					bit_idx_r   <= 4'h0;
					// Ten-bit read opens as a write, then restarts
					shift_r     <= ten_bit_mode_r ? {target_addr_first_r[7:1], 1'b0}
						: target_addr_first_r;
					state_r     <= ST_START_A;
					reload_r    <= 1'b1;
				end
			end
			ST_START_A: begin
				if (expired) begin
					state_r  <= ST_START_B;
					reload_r <= 1'b1;
				end
			end
			ST_START_B: begin
				if (expired) begin
					state_r  <= ST_BIT_LOW;
					reload_r <= 1'b1;
				end
			end
			ST_BIT_LOW: begin
				if (expired) begin
					state_r  <= ST_BIT_HIGH;
					reload_r <= 1'b1;
				end
			end
			ST_BIT_HIGH: begin
				if (expired) begin
					reload_r <= 1'b1;
					if (!bit_idx_r[3]) begin
						bit_idx_r <= bit_idx_r + 4'h1;
						shift_r   <= {shift_r[6:0], sda_s_r};
						state_r   <= ST_BIT_LOW;
						if ((phase_r == PH_DATA) & (bit_idx_r == 4'h7)) begin
							push_r      <= 1'b1;
							push_data_r <= {shift_r[6:0], sda_s_r};
						end
					end else if (phase_r == PH_DATA) begin
						rx_cnt_r <= rx_cnt_r + 9'h001;
						state_r  <= last ? ST_STOP_LOW : ST_WAIT_FIFO;
					end else if (sda_s_r) begin
						nack_flag_r <= 1'b1;
						state_r     <= ST_STOP_LOW;
					end else if ((phase_r == PH_ADR1) & ten_r & ~adr2_sent_r) begin
						phase_r   <= PH_ADR2;
						bit_idx_r <= 4'h0;
						shift_r   <= target_addr_low_byte_r;
						state_r   <= ST_BIT_LOW;
					end else if (phase_r == PH_ADR2) begin
						adr2_sent_r <= 1'b1;
						state_r     <= rd_r ? ST_RS_LOW : ST_STOP_LOW;
					end else begin
						phase_r <= PH_DATA;
						state_r <= rd_r ? ST_WAIT_FIFO : ST_STOP_LOW;
					end
				end
			end
			ST_WAIT_FIFO: begin
				// SCL held low while the buffer is full
				if (fifo_ready & ~push_r) begin
					bit_idx_r <= 4'h0;
					state_r   <= ST_BIT_LOW;
					reload_r  <= 1'b1;
				end
			end
			ST_RS_LOW: begin
				if (expired) begin
					phase_r   <= PH_ADR1;
					bit_idx_r <= 4'h0;
					shift_r   <= {target_addr_first_r[7:1], 1'b1};
					state_r   <= ST_START_A;
					reload_r  <= 1'b1;
				end
			end
			ST_STOP_LOW: begin
				if (expired) begin
					state_r  <= ST_STOP_HIGH;
					reload_r <= 1'b1;
				end
			end
			ST_STOP_HIGH: begin
				if (expired) begin
					state_r  <= ST_STOP_END;
					reload_r <= 1'b1;
				end
			end
			ST_STOP_END: begin
				if (expired) begin
					done_flag_r <= 1'b1;
					state_r     <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // i2c_master_addr_count_clkdiv

// ### rtl/i2c_rd_map.vh
`ifndef I2C_RD_MAP_VH
`define I2C_RD_MAP_VH
// ==========================================
// Register byte addresses
`define OFS_CTRL          32'hffff0900
`define OFS_STATUS        32'hffff0904
`define OFS_RX_DATA       32'hffff0908
`define OFS_READ_LENGTH   32'hffff0910
`define OFS_RX_PROGRESS   32'hffff0914
`define OFS_ADDR_FIRST    32'hffff0918
`define OFS_ADDR_LOW      32'hffff091c
`define OFS_SCL_DIVIDER   32'hffff0924
`define OFS_TARGET_CTRL   32'hffff0928
// ==========================================
// Reset values
`define RST_READ_LENGTH   16'h0000
`define RST_RX_PROGRESS   8'h00
`define RST_ADDR_FIRST    8'h00
`define RST_ADDR_LOW      8'h00
`define RST_SCL_DIVIDER   16'h1f1f
`define RST_TARGET_CTRL   11'h000
// ==========================================
// Field positions
`define READ_EXTEND_BIT   8
`define DIR_READ_BIT      0
`define TX_IRQ_EN_BIT     10
`define CTRL_START_BIT    0
`define CTRL_TEN_BIT      1
`define STAT_BUSY_BIT     0
`define STAT_NACK_BIT     1
`define STAT_DONE_BIT     2
`define TEN_BIT_PREFIX    5'h1e
// ==========================================
// Bus answers and receive buffer size
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define FIFO_DEPTH        32
`define FIFO_AW           5
`endif

// ### rtl/rx_byte_fifo.v
module rx_byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out,
	output wire [AW:0]      level_out
);
	// ==========================================
	// Storage and pointers
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW:0]      wr_ptr_r;
	reg [AW:0]      rd_ptr_r;
	wire            push;
	wire            pop;

	assign level_out     = wr_ptr_r - rd_ptr_r;
	assign in_ready_out  = (level_out != DEPTH[AW:0]);
	assign out_valid_out = (level_out != {(AW+1){1'b0}});
	assign out_data_out  = mem_r[rd_ptr_r[AW-1:0]];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_ready_in & out_valid_out;

	always @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
		end
	end

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule // rx_byte_fifo

// ### rtl/scl_span_timer.v
module scl_span_timer (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       load_in,
	input  wire [7:0] span_in,
	output wire       expired_out
);
	// ==========================================
	// Counts span_in + 1 cycles after load drops
	reg [7:0] cnt_r;
	reg       busy_r;

	assign expired_out = busy_r & (cnt_r == 8'h00) & ~load_in;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_r  <= 8'h00;
			busy_r <= 1'b0;
		end else if (load_in) begin
			cnt_r  <= span_in;
			busy_r <= 1'b1;
		end else if (busy_r) begin
			if (cnt_r == 8'h00) begin
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule // scl_span_timer

// ### test/i2c_rd_checker.sv
// ==========================================
// Bus and pin checks
module i2c_rd_checker (
	input wire        clk_in,
	input wire        rst_n_in,
	input wire        s_axi_awvalid_in,
	input wire        s_axi_awready_out,
	input wire        s_axi_wvalid_in,
	input wire        s_axi_wready_out,
	input wire [1:0]  s_axi_bresp_out,
	input wire        s_axi_bvalid_out,
	input wire        s_axi_bready_in,
	input wire        s_axi_arvalid_in,
	input wire        s_axi_arready_out,
	input wire [31:0] s_axi_rdata_out,
	input wire [1:0]  s_axi_rresp_out,
	input wire        s_axi_rvalid_out,
	input wire        s_axi_rready_in,
	input wire        scl_out,
	input wire        sda_out,
	input wire        scl_oe_out,
	input wire        sda_oe_out,
	input wire        target_tx_done_in,
	input wire        target_tx_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_irq_has_cause:
		assert property (target_tx_irq_out |-> $past(target_tx_done_in)) else $error("irq no done");
	a_irq_one_pulse:
		assert property (target_tx_irq_out && !target_tx_done_in |=> !target_tx_irq_out)
			else $error("irq too long");
	a_bresp_held:
		assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
			&& $stable(s_axi_bresp_out)) else $error("write answer dropped");
	a_rdata_held:
		assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
			&& $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("read answer dropped");
	a_ar_gate:
		assert property (s_axi_arready_out != s_axi_rvalid_out) else $error("arready wrong");
	a_read_answer:
		assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
			else $error("read late");
	a_write_answer:
		assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
			&& s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write late");
	a_pins_open:
		assert property (!scl_out && !sda_out) else $error("pin driven high");
	a_sda_hold:
		assert property ($changed(scl_oe_out) |-> $stable(sda_oe_out))
			else $error("sda moved with scl");
	a_rresp_legal:
		assert property (s_axi_rvalid_out |-> s_axi_rresp_out == 2'h0 || s_axi_rresp_out == 2'h2)
			else $error("bad rresp");
	c_irq: cover property (target_tx_irq_out);
	c_rd_wait: cover property (s_axi_rvalid_out && !s_axi_rready_in);
	c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule // i2c_rd_checker

// ### test/i2c_target_model.sv
// ==========================================
// Target device on the two-wire bus
module i2c_target_model #(
	parameter logic [6:0] ADDR7  = 7'h52,
	parameter logic [9:0] ADDR10 = 10'h23c
) (
	input  wire logic   scl_in,
	input  wire logic   sda_in,
	input  wire logic   stretch_in,
	output logic        scl_oe_out,
	output logic        sda_oe_out,
	output int          sent_out,
	output logic [31:0] log_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh, dat;
	logic       act, first, tx, pend, ok, tenw;
	int         bitn;
	initial begin
		{scl_oe_out, sda_oe_out, act, tx, pend, tenw} = 6'h0;
		sent_out = 0;
		log_out = 32'h0;
	end
	always @(negedge sda_in) if (scl_in) begin
		{act, first, tx, sda_oe_out} = 4'hc;
		bitn = 0;
	end
	always @(posedge sda_in) if (scl_in) {act, tx} = 2'h0;
	always @(posedge scl_in) if (act) begin
		if (bitn < 8) sh = {sh[6:0], sda_in};
		if (bitn == 8 && tx) begin
			sent_out++;
			pend = !sda_in;
		end
		bitn++;
	end
	always @(negedge scl_in) if (act && stretch_in) begin
		scl_oe_out = 1'b1;
		#40 scl_oe_out = 1'b0;
	end
	always @(negedge scl_in) if (act) begin
		if (bitn == 8 && !tx) begin
			log_out = {log_out[23:0], sh};
			ok = first ? (sh[7:1] == ADDR7
				|| (sh[7:3] == 5'h1e && sh[2:1] == ADDR10[9:8]))
				: (!tenw || sh == ADDR10[7:0]);
			tenw = first && ok && !sh[0] && sh[7:3] == 5'h1e;
			pend = first && ok && sh[0];
			first = 1'b0;
			sda_oe_out = ok;
		end else if (bitn == 9) begin
			bitn = 0;
			tx = pend;
			dat = 8'h5a ^ sent_out[7:0];
			sda_oe_out = tx && !dat[7];
		end else if (tx) sda_oe_out = bitn < 8 && !dat[7 - bitn];
	end
endmodule // i2c_target_model

// ### test/test_i2c_master_addr_count_clkdiv.sv
`include "i2c_rd_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module test_i2c_master_addr_count_clkdiv;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, done, stretch, pscl;
	logic [31:0] awaddr, wdata, araddr, rd, st, lg;
	logic [1:0]  rsp;
	wire  [31:0] rdata;
	wire  [1:0]  bresp, rresp;
	wire         awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, m_scl, m_sda;
	wire         scl_w = !(scl_oe | m_scl);
	wire         sda_w = !(sda_oe | m_sda);
	int          miscompares, compares, irqs, cnt, lo_last, hi_last, sent;
	logic [31:0] ra [6] = '{`OFS_READ_LENGTH, `OFS_RX_PROGRESS, `OFS_ADDR_FIRST, `OFS_ADDR_LOW,
		`OFS_SCL_DIVIDER, `OFS_TARGET_CTRL};
	logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1f1f, 32'h0};
	logic [31:0] rw [6] = '{32'h1ff, 32'h0, 32'hff, 32'hff, 32'hffff, 32'h7ff};
	i2c_master_addr_count_clkdiv u_i2c_master_addr_count_clkdiv (
		.clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
		.sda_oe_out(sda_oe), .target_tx_done_in(done), .target_tx_irq_out(irq));
	i2c_target_model u_i2c_target_model (.scl_in(scl_w), .sda_in(sda_w), .stretch_in(stretch),
		.scl_oe_out(m_scl), .sda_oe_out(m_sda), .sent_out(sent), .log_out(lg));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================
	// Monitors
	always @(posedge clk) begin
		if (irq === 1'b1) irqs++;
		if (scl_w !== pscl) begin
			if (sent == 1 && scl_w) lo_last = cnt;
			if (sent == 1 && !scl_w) hi_last = cnt;
			cnt = 1;
		end else cnt++;
		pscl = scl_w;
	end
	// ==========================================
	// Bus tasks
	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic fail;
		miscompares++;
		end_sim();
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1 && !bready) bready <= 1'b1;
		end while (!(bvalid === 1'b1 && bready) && n < 200);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
		if (n >= 200) fail();
	endtask
	task automatic rdr(input logic [31:0] a);
		int n;
		n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1 && !rready) rready <= 1'b1;
		end while (!(rvalid === 1'b1 && rready) && n < 200);
		rd  = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
		if (n >= 200) fail();
	endtask
	// ==========================================
	// One transfer, drained through the data register
	task automatic run(input logic [7:0] a0, a1, input logic [8:0] len, input logic ten,
		input int nb, input logic [31:0] msk, lgx, input logic nk, fl);
		int n, got, s0;
		s0 = sent;
		got = 0;
		n = 0;
		wr(`OFS_ADDR_FIRST, {24'h0, a0});
		wr(`OFS_ADDR_LOW, {24'h0, a1});
		wr(`OFS_READ_LENGTH, {23'h0, len});
		wr(`OFS_CTRL, {30'h0, ten, 1'b0});
		wr(`OFS_CTRL, {30'h0, ten, 1'b1});
		do begin
			rdr(`OFS_STATUS);
			st = rd;
			n++;
			if (st[8:3] != 0 && (!fl || got > 0 || st[8:3] == 32)) begin
				if (fl && got == 0) begin
					wr(`OFS_READ_LENGTH, 32'h0);
					repeat (200) @(posedge clk);
					`CHK(sent - s0, 32)
				end
				rdr(`OFS_RX_DATA);
				`CHK(rd[7:0], 8'h5a ^ 8'(s0 + got))
				got++;
			end
		end while (!((st[1] | st[2]) === 1'b1 && st[0] === 1'b0 && st[8:3] == 0) && n < 30000);
		if (n >= 30000) fail();
		`CHK(got, nb)
		`CHK(sent - s0, nb)
		`CHK(lg & msk, lgx)
		`CHK(st[1], nk)
		rdr(`OFS_RX_PROGRESS);
		`CHK(rd, nb & 32'hff)
		wr(`OFS_STATUS, 32'h4);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, done, stretch} = 8'h0;
		{awaddr, wdata, araddr} = 96'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rdr(ra[i]);
			`CHK(rd, rv[i])
			wr(ra[i], 32'hffffffff);
			rdr(ra[i]);
			`CHK(rd, rw[i])
			wr(ra[i], rv[i]);
		end
		wr(32'hffff090c, 32'h0);
		`CHK(rsp, `RESP_SLVERR)
		rdr(32'hffff0920);
		`CHK(rsp, `RESP_SLVERR)
		for (int e = 1; e >= 0; e--) begin
			wr(`OFS_TARGET_CTRL, e << 10);
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
			repeat (3) @(posedge clk);
			`CHK(irqs, 1)
		end
		wr(`OFS_SCL_DIVIDER, 32'h0408);
		run(8'ha5, 8'h00, 9'h002, 0, 3, 32'hffffffff, 32'ha5, 0, 0);
		`CHK(lo_last inside {[9:11]}, 1'b1)
		`CHK(hi_last inside {[5:8]}, 1'b1)
		stretch <= 1'b1;
		run(8'ha5, 8'h00, 9'h000, 0, 1, 32'hff, 32'ha5, 0, 0);
		stretch <= 1'b0;
		run(8'hf5, 8'h3c, 9'h001, 1, 2, 32'hffffff, 32'hf43cf5, 0, 0);
		run(8'h77, 8'h00, 9'h000, 0, 0, 32'hff, 32'h77, 1, 0);
		run(8'ha4, 8'h00, 9'h000, 0, 0, 32'hff, 32'ha4, 0, 0);
		wr(`OFS_SCL_DIVIDER, 32'h0101);
		run(8'ha5, 8'h00, 9'h100, 0, 257, 32'hff, 32'ha5, 0, 1);
		end_sim();
	end
endmodule // test_i2c_master_addr_count_clkdiv
bind i2c_master_addr_count_clkdiv i2c_rd_checker u_i2c_rd_checker (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.scl_out(scl_out), .sda_out(sda_out), .target_tx_done_in(target_tx_done_in),
	.scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out),
	.target_tx_irq_out(target_tx_irq_out));
